// File: epis_pkg.sv
package epis_pkg;
    // register indices on the plain register port
    localparam logic [1:0] ADDR_MCU_CONTROL  = 2'h0;
    localparam logic [1:0] ADDR_GEN_IRQ_CTRL = 2'h1;
    localparam logic [1:0] ADDR_IRQ_FLAGS    = 2'h2;
    localparam logic [1:0] ADDR_MCU_CTRL_ST  = 2'h3;

    // reset values
    localparam logic [7:0] MCU_CONTROL_RST = 8'h00;
    localparam logic [7:0] GEN_IRQ_RST     = 8'h00;
    localparam logic [7:0] FLAGS_RST       = 8'h00;
    localparam logic [7:0] CTRL_ST_RST     = 8'h00;
    localparam logic [2:0] PIN_SYNC_RST    = 3'h7;

    // mcu_control fields
    localparam int SLEEP_SELECT_BIT2 = 7;
    localparam int SLEEP_ALLOW       = 6;
    localparam int SLEEP_SELECT_BIT1 = 5;
    localparam int SLEEP_SELECT_BIT0 = 4;
    localparam int PIN_ONE_SENSE_LSB  = 2;
    localparam int PIN_ZERO_SENSE_LSB = 0;

    // enable, mask and flag layout (same positions in two registers)
    localparam int BIT_PIN_ONE  = 7;
    localparam int BIT_PIN_ZERO = 6;
    localparam int BIT_PIN_TWO  = 5;

    // mcu_control_status field
    localparam int PIN_TWO_EDGE_SELECT = 6;

    // sense encodings
    localparam logic [1:0] SENSE_LOW     = 2'h0;
    localparam logic [1:0] SENSE_CHANGE  = 2'h1;
    localparam logic [1:0] SENSE_FALLING = 2'h2;
    localparam logic [1:0] SENSE_RISING  = 2'h3;

    // sleep mode codes
    localparam logic [2:0] SLEEP_IDLE       = 3'h0;
    localparam logic [2:0] SLEEP_POWER_DOWN = 3'h2;

    // watchdog oscillator samples needed for level wake-up
    localparam logic [1:0] WAKE_SAMPLES = 2'h2;
endpackage

// File: epis_sync.sv
`timescale 1ns/100ps
`default_nettype none
module epis_sync #(
    parameter int         W       = 3,
    parameter logic [2:0] RST_VAL = epis_pkg::PIN_SYNC_RST
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         rst_n,
    // data
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // two flops; the first is read only by the second
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta_q <= RST_VAL[W-1:0];
            q      <= RST_VAL[W-1:0];
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
`default_nettype wire

// File: epis_top.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - pin activity raises requests even while the pin is driven as output
// - pins zero and one: low, change, falling, rising; pin two edge only
// - enabled level mode requests for as long as the pin stays low
// - pin zero and one edges are seen only while the i/o clock runs
// - low level and pin two edges are seen in every sleep mode
// - i/o clock stops in every sleep mode but idle
// - power-down level wake needs two low watchdog oscillator samples
// - wake after both samples; no request if the level has gone
// - a request needs both the global enable and the pin enable
// - pins sampled before edge detection; one-clock pulses suffice
// - pin one sense bits 3:2: low, change, falling, rising
// - 8-bit control: sleep select and allow in 7:4, senses in 3:0
// - pin zero sense bits 1:0 use the same encoding
// - pin two edge select: 0 falling, 1 rising; change may raise event
// - flags set on edges, clear on service or write one, zero in level
module epis_top (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // register port
    input  wire logic [1:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output var  logic [7:0] reg_rdata,
    // interrupt pins, pad input side
    input  wire logic       ext_irq_pin_zero,
    input  wire logic       ext_irq_pin_one,
    input  wire logic       ext_irq_pin_two,
    // core
    input  wire logic       core_global_ie,
    input  wire logic       core_sleeping,
    input  wire logic [2:0] core_service,
    input  wire logic       wdt_osc_tick,
    // requests and wake
    output var  logic       req_pin_zero,
    output var  logic       req_pin_one,
    output var  logic       req_pin_two,
    output var  logic       irq,
    output var  logic       io_clk_run,
    output var  logic       wake
);
    logic [7:0] mcu_control_q;
    logic [7:0] general_irq_control_q;
    logic [7:0] irq_flags_q;
    logic [7:0] irq_flags_d;
    logic [7:0] mcu_control_status_q;
    logic [2:0] pin_s;
    logic [1:0] prev01_q;
    logic       act2_prev_q;
    logic       act2;
    logic [1:0] lvl_cnt0_q;
    logic [1:0] lvl_cnt1_q;
    logic [2:0] sleep_mode;
    logic       io_run;
    logic       pwr_down;
    logic [1:0] sense0;
    logic [1:0] sense1;
    logic       edge0;
    logic       edge1;
    logic       edge2;
    logic       lvl0;
    logic       lvl1;
    logic       en0;
    logic       en1;
    logic       en2;
    logic       r0;
    logic       r1;
    logic       r2;
    logic       wr_ctrl;
    logic       wr_gic;
    logic       wr_flags;
    logic       wr_st;

    // edge event for one sampled pin under a sense code
    function automatic logic sense_edge(input logic [1:0] sense,
                                        input logic cur,
                                        input logic prev);
        case (sense)
            epis_pkg::SENSE_CHANGE:  sense_edge = cur ^ prev;
            epis_pkg::SENSE_FALLING: sense_edge = prev & ~cur;
            epis_pkg::SENSE_RISING:  sense_edge = cur & ~prev;
            default:                 sense_edge = 1'b0;
        endcase
    endfunction

    // next low-sample count on a watchdog oscillator tick
    function automatic logic [1:0] lvl_count(input logic [1:0] cnt,
                                              input logic low_armed,
                                              input logic tick);
        if (!low_armed)
            lvl_count = 2'h0;
        else if (tick && cnt != epis_pkg::WAKE_SAMPLES)
            lvl_count = cnt + 2'h1;
        else
            lvl_count = cnt;
    endfunction

    // pad levels, read whatever the pin direction
    epis_sync #(
        .W       (3),
        .RST_VAL (epis_pkg::PIN_SYNC_RST)
    ) u_pin_sync (
        .clock (clock),
        .rst_n (rst_n),
        .d     ({ext_irq_pin_two, ext_irq_pin_one, ext_irq_pin_zero}),
        .q     (pin_s)
    );

    // register write decode
    assign wr_ctrl  = reg_wr && reg_addr == epis_pkg::ADDR_MCU_CONTROL;
    assign wr_gic   = reg_wr && reg_addr == epis_pkg::ADDR_GEN_IRQ_CTRL;
    assign wr_flags = reg_wr && reg_addr == epis_pkg::ADDR_IRQ_FLAGS;
    assign wr_st    = reg_wr && reg_addr == epis_pkg::ADDR_MCU_CTRL_ST;

    // control field decode
    assign sleep_mode = {mcu_control_q[epis_pkg::SLEEP_SELECT_BIT2],
                         mcu_control_q[epis_pkg::SLEEP_SELECT_BIT1],
                         mcu_control_q[epis_pkg::SLEEP_SELECT_BIT0]};
    assign sense0 = mcu_control_q[epis_pkg::PIN_ZERO_SENSE_LSB +: 2];
    assign sense1 = mcu_control_q[epis_pkg::PIN_ONE_SENSE_LSB +: 2];
    assign en0 = general_irq_control_q[epis_pkg::BIT_PIN_ZERO];
    assign en1 = general_irq_control_q[epis_pkg::BIT_PIN_ONE];
    assign en2 = general_irq_control_q[epis_pkg::BIT_PIN_TWO];

    // i/o clock runs awake or in idle sleep only
    assign io_run = !core_sleeping
                    || sleep_mode == epis_pkg::SLEEP_IDLE;
    assign pwr_down = core_sleeping
                      && sleep_mode == epis_pkg::SLEEP_POWER_DOWN;

    // synchronous edges on pins zero and one
    assign edge0 = io_run
                   && sense_edge(sense0, pin_s[0], prev01_q[0]);
    assign edge1 = io_run
                   && sense_edge(sense1, pin_s[1], prev01_q[1]);

    // pin two: edge only, active level picked by the select bit
    assign act2 = mcu_control_status_q[epis_pkg::PIN_TWO_EDGE_SELECT]
                  ? pin_s[2] : ~pin_s[2];
    assign edge2 = act2 & ~act2_prev_q;

    // level requests, independent of the i/o clock
    assign lvl0 = sense0 == epis_pkg::SENSE_LOW && !pin_s[0];
    assign lvl1 = sense1 == epis_pkg::SENSE_LOW && !pin_s[1];

    // request terms: global and pin enables both needed
    assign r0 = core_global_ie && en0
                && (irq_flags_q[epis_pkg::BIT_PIN_ZERO] || lvl0);
    assign r1 = core_global_ie && en1
                && (irq_flags_q[epis_pkg::BIT_PIN_ONE] || lvl1);
    assign r2 = core_global_ie && en2
                && irq_flags_q[epis_pkg::BIT_PIN_TWO];

    // mcu_control: all bits read-write, reset to zero
    always_ff @(posedge clock) begin
        if (!rst_n)
            mcu_control_q <= epis_pkg::MCU_CONTROL_RST;
        else if (wr_ctrl)
            mcu_control_q <= reg_wdata;
    end

    // general_irq_control: pin enables, also the interrupt mask
    always_ff @(posedge clock) begin
        if (!rst_n)
            general_irq_control_q <= epis_pkg::GEN_IRQ_RST;
        else if (wr_gic) begin
            general_irq_control_q <= 8'h00;
            general_irq_control_q[epis_pkg::BIT_PIN_ONE] <=
                reg_wdata[epis_pkg::BIT_PIN_ONE];
            general_irq_control_q[epis_pkg::BIT_PIN_ZERO] <=
                reg_wdata[epis_pkg::BIT_PIN_ZERO];
            general_irq_control_q[epis_pkg::BIT_PIN_TWO] <=
                reg_wdata[epis_pkg::BIT_PIN_TWO];
        end
    end

    // mcu_control_status: pin two edge select only
    always_ff @(posedge clock) begin
        if (!rst_n)
            mcu_control_status_q <= epis_pkg::CTRL_ST_RST;
        else if (wr_st) begin
            mcu_control_status_q <= 8'h00;
            mcu_control_status_q[epis_pkg::PIN_TWO_EDGE_SELECT] <=
                reg_wdata[epis_pkg::PIN_TWO_EDGE_SELECT];
        end
    end

    // flag next state: write and service clears, then sets, so a set wins; level-mode zeroing comes last
    always_comb begin
        irq_flags_d = irq_flags_q;
        if (wr_flags)
            irq_flags_d = irq_flags_q & ~reg_wdata;
        if (core_service[0])
            irq_flags_d[epis_pkg::BIT_PIN_ZERO] = 1'b0;
        if (core_service[1])
            irq_flags_d[epis_pkg::BIT_PIN_ONE] = 1'b0;
        if (core_service[2])
            irq_flags_d[epis_pkg::BIT_PIN_TWO] = 1'b0;
        if (edge0)
            irq_flags_d[epis_pkg::BIT_PIN_ZERO] = 1'b1;
        if (edge1)
            irq_flags_d[epis_pkg::BIT_PIN_ONE] = 1'b1;
        if (edge2)
            irq_flags_d[epis_pkg::BIT_PIN_TWO] = 1'b1;
        if (sense0 == epis_pkg::SENSE_LOW)
            irq_flags_d[epis_pkg::BIT_PIN_ZERO] = 1'b0;
        if (sense1 == epis_pkg::SENSE_LOW)
            irq_flags_d[epis_pkg::BIT_PIN_ONE] = 1'b0;
        irq_flags_d = irq_flags_d
                      & {1'b1, 1'b1, 1'b1, 5'h00};
    end

    always_ff @(posedge clock) begin
        if (!rst_n)
            irq_flags_q <= epis_pkg::FLAGS_RST;
        else
            irq_flags_q <= irq_flags_d;
    end

    // previous samples; pins zero/one hold while the i/o clock stops
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prev01_q    <= epis_pkg::PIN_SYNC_RST[1:0];
            act2_prev_q <= 1'b0;
        end else begin
            if (io_run)
                prev01_q <= pin_s[1:0];
            act2_prev_q <= act2;
        end
    end

    // watchdog oscillator low-level sampling for power-down wake
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            lvl_cnt0_q <= 2'h0;
            lvl_cnt1_q <= 2'h0;
        end else begin
            lvl_cnt0_q <= lvl_count(lvl_cnt0_q, en0 && lvl0,
                                    wdt_osc_tick);
            lvl_cnt1_q <= lvl_count(lvl_cnt1_q, en1 && lvl1,
                                    wdt_osc_tick);
        end
    end

    // wake: enabled events or levels; in power-down only pin two flag or two-sample level
    always_ff @(posedge clock) begin
        if (!rst_n)
            wake <= 1'b0;
        else if (!core_sleeping)
            wake <= 1'b0;
        else if (pwr_down)
            wake <= wake
                    || lvl_cnt0_q == epis_pkg::WAKE_SAMPLES
                    || lvl_cnt1_q == epis_pkg::WAKE_SAMPLES
                    || (en2 && irq_flags_q[epis_pkg::BIT_PIN_TWO]);
        else
            wake <= (en0 && (lvl0 || irq_flags_q[epis_pkg::BIT_PIN_ZERO]))
                    || (en1 && (lvl1 || irq_flags_q[epis_pkg::BIT_PIN_ONE]))
                    || (en2 && irq_flags_q[epis_pkg::BIT_PIN_TWO]);
    end

    // registered requests; a vanished level gives none
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            req_pin_zero <= 1'b0;
            req_pin_one  <= 1'b0;
            req_pin_two  <= 1'b0;
            irq          <= 1'b0;
            io_clk_run   <= 1'b1;
        end else begin
            req_pin_zero <= r0;
            req_pin_one  <= r1;
            req_pin_two  <= r2;
            irq          <= r0 || r1 || r2;
            io_clk_run   <= io_run;
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clock) begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (reg_rd) begin
            case (reg_addr)
                epis_pkg::ADDR_MCU_CONTROL:  reg_rdata <= mcu_control_q;
                epis_pkg::ADDR_GEN_IRQ_CTRL: reg_rdata <= general_irq_control_q;
                epis_pkg::ADDR_IRQ_FLAGS:    reg_rdata <= irq_flags_q;
                epis_pkg::ADDR_MCU_CTRL_ST:  reg_rdata <= mcu_control_status_q;
                default:                     reg_rdata <= 8'h00;
            endcase
        end else
            reg_rdata <= 8'h00;
    end
endmodule
`default_nettype wire

// File: epis_chk.sv
`timescale 1ns/100ps
`default_nettype none
module epis_chk (
    // clock and reset
    input wire logic       clock,
    input wire logic       rst_n,
    // register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // pins
    input wire logic       ext_irq_pin_zero,
    input wire logic       ext_irq_pin_one,
    input wire logic       ext_irq_pin_two,
    // core
    input wire logic       core_global_ie,
    input wire logic       core_sleeping,
    input wire logic [2:0] core_service,
    input wire logic       wdt_osc_tick,
    // requests and wake
    input wire logic       req_pin_zero,
    input wire logic       req_pin_one,
    input wire logic       req_pin_two,
    input wire logic       irq,
    input wire logic       io_clk_run,
    input wire logic       wake
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // mirror of control and enable registers
    logic [7:0] ctl_q;
    logic [7:0] en_q;
    logic [2:0] mode;
    assign mode = {ctl_q[7], ctl_q[5], ctl_q[4]};
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctl_q <= 8'h00;
            en_q  <= 8'h00;
        end else if (reg_wr && reg_addr == epis_pkg::ADDR_MCU_CONTROL) begin
            ctl_q <= reg_wdata;
        end else if (reg_wr && reg_addr == epis_pkg::ADDR_GEN_IRQ_CTRL) begin
            en_q  <= reg_wdata & 8'hE0;
        end
    end

    irq_is_or_a: assert property (irq == (
        req_pin_zero | req_pin_one | req_pin_two))
        else $error("irq differs from request or");
    gie_gate_a: assert property (!core_global_ie |=> !irq)
        else $error("request without global enable");
    pin_mask_a: assert property (!en_q[5] |=> !req_pin_two)
        else $error("pin two request while disabled");
    level_req_a: assert property (
        (ctl_q[3:2] == epis_pkg::SENSE_LOW && en_q[7] && core_global_ie &&
        !ext_irq_pin_one)[*4] |-> req_pin_one)
        else $error("no request on held low level");
    level_drop_a: assert property (
        (ctl_q[3:2] == epis_pkg::SENSE_LOW && ext_irq_pin_one)[*4]
        |-> !req_pin_one)
        else $error("level request without low pin");
    rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    rd_ctl_a: assert property (reg_rd && reg_addr == 2'h0
        |=> reg_rdata == $past(ctl_q)) else $error("control readback");
    io_stop_a: assert property (core_sleeping &&
        mode != epis_pkg::SLEEP_IDLE |=> !io_clk_run)
        else $error("io clock runs in deep sleep");
    io_run_a: assert property (!core_sleeping ||
        mode == epis_pkg::SLEEP_IDLE |=> io_clk_run)
        else $error("io clock stopped while awake or idle");
    wake_awake_a: assert property (!core_sleeping |=> !wake)
        else $error("wake while not sleeping");
endmodule

bind epis_top epis_chk i_chk (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .ext_irq_pin_zero, .ext_irq_pin_one,
    .ext_irq_pin_two, .core_global_ie, .core_sleeping, .core_service,
    .wdt_osc_tick, .req_pin_zero, .req_pin_one, .req_pin_two, .irq,
    .io_clk_run, .wake);
`default_nettype wire

// File: epis_pin_src.sv
`timescale 1ns/100ps
`default_nettype none
module epis_pin_src (
    // clock
    input  wire logic       clock,
    // commanded levels
    input  wire logic [2:0] lvl,
    // pin levels, idle high
    output var  logic [2:0] pins
);
    initial pins = 3'h7;
    // a level is held until the bench commands another
    always @(posedge clock) begin
        pins <= lvl;
    end
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic       clock;
    logic       rst_n;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       core_global_ie;
    logic       core_sleeping;
    logic [2:0] core_service;
    logic       wdt_osc_tick;
    logic [2:0] pin_lvl;
    logic [2:0] pins;
    logic       req_pin_zero;
    logic       req_pin_one;
    logic       req_pin_two;
    logic       irq;
    logic       io_clk_run;
    logic       wake;
    logic [7:0] fb;
    int         fails;
    int         n_tests;

    epis_pin_src i_src (.clock(clock), .lvl(pin_lvl), .pins(pins));
    epis_top i_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ext_irq_pin_zero(pins[0]),
        .ext_irq_pin_one(pins[1]), .ext_irq_pin_two(pins[2]),
        .core_global_ie(core_global_ie), .core_sleeping(core_sleeping),
        .core_service(core_service), .wdt_osc_tick(wdt_osc_tick),
        .req_pin_zero(req_pin_zero), .req_pin_one(req_pin_one),
        .req_pin_two(req_pin_two), .irq(irq), .io_clk_run(io_clk_run),
        .wake(wake));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_tests++;
        if (s !== e) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        @(negedge clock);
        chk(reg_rdata, e);
    endtask

    task automatic pin(input int n, input logic v);
        @(posedge clock);
        pin_lvl[n] <= v;
    endtask

    task automatic tick;
        @(posedge clock);
        wdt_osc_tick <= 1'b1;
        @(posedge clock);
        wdt_osc_tick <= 1'b0;
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge clock);
        fails++;
        results();
    end

    initial begin
        rst_n = 1'b0;
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        core_global_ie = 1'b0;
        core_sleeping = 1'b0;
        core_service = 3'h0;
        wdt_osc_tick = 1'b0;
        pin_lvl = 3'h7;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        wt(1);
        chk({7'h00, io_clk_run}, 8'h01);
        for (int a = 0; a < 4; a++) rd(2'(a), 8'h00);
        wr(2'h0, 8'hFF);
        rd(2'h0, 8'hFF);
        wr(2'h1, 8'hFF);
        rd(2'h1, 8'hE0);
        wr(2'h3, 8'hFF);
        rd(2'h3, 8'h40);
        rd(2'h2, 8'h20);
        wr(2'h0, 8'h00);
        wr(2'h1, 8'h00);
        wr(2'h3, 8'h00);
        $display("register test done");
        for (int p = 0; p < 2; p++) begin
            fb = (p == 0) ? 8'h40 : 8'h80;
            for (int m = 1; m < 4; m++) begin
                wr(2'h0, 8'(m << (2 * p)));
                wr(2'h2, 8'hE0);
                pin(p, 1'b0);
                wt(6);
                rd(2'h2, (m != 3) ? fb : 8'h00);
                wr(2'h2, 8'hE0);
                pin(p, 1'b1);
                wt(6);
                rd(2'h2, (m != 2) ? fb : 8'h00);
            end
        end
        $display("sense test done");
        wr(2'h0, 8'h08);
        wr(2'h2, 8'hE0);
        pin(1, 1'b0);
        @(posedge clock);
        pin(1, 1'b1);
        wt(6);
        rd(2'h2, 8'h80);
        wr(2'h2, 8'hE0);
        wr(2'h1, 8'h80);
        core_global_ie <= 1'b1;
        pin(1, 1'b0);
        wt(6);
        chk({6'h00, req_pin_one, irq}, 8'h03);
        @(posedge clock);
        core_service <= 3'h2;
        @(posedge clock);
        core_service <= 3'h0;
        wt(3);
        chk({7'h00, req_pin_one}, 8'h00);
        pin(1, 1'b1);
        core_global_ie <= 1'b0;
        pin(1, 1'b0);
        wt(6);
        chk({7'h00, irq}, 8'h00);
        rd(2'h2, 8'h80);
        pin(1, 1'b1);
        wr(2'h2, 8'hE0);
        $display("request test done");
        wr(2'h0, 8'h00);
        core_global_ie <= 1'b1;
        pin(1, 1'b0);
        wt(8);
        chk({7'h00, req_pin_one}, 8'h01);
        rd(2'h2, 8'h00);
        pin(1, 1'b1);
        wt(6);
        chk({7'h00, req_pin_one}, 8'h00);
        $display("level test done");
        wr(2'h1, 8'h20);
        pin(2, 1'b0);
        wt(6);
        chk({7'h00, req_pin_two}, 8'h01);
        rd(2'h2, 8'h20);
        wr(2'h1, 8'h00);
        wr(2'h3, 8'h40);
        wr(2'h2, 8'h20);
        wr(2'h1, 8'h20);
        pin(2, 1'b1);
        wt(6);
        chk({7'h00, req_pin_two}, 8'h01);
        wr(2'h1, 8'h00);
        wr(2'h3, 8'h00);
        wr(2'h2, 8'hE0);
        $display("pin two test done");
        wr(2'h0, 8'h62);
        core_sleeping <= 1'b1;
        wt(3);
        chk({7'h00, io_clk_run}, 8'h00);
        pin(0, 1'b0);
        wt(6);
        rd(2'h2, 8'h00);
        pin(0, 1'b1);
        pin(2, 1'b0);
        wt(6);
        rd(2'h2, 8'h20);
        wr(2'h2, 8'hE0);
        pin(2, 1'b1);
        wr(2'h0, 8'h60);
        wr(2'h1, 8'h40);
        pin(0, 1'b0);
        wt(5);
        chk({7'h00, wake}, 8'h00);
        tick();
        wt(2);
        chk({7'h00, wake}, 8'h00);
        tick();
        wt(2);
        chk({7'h00, wake}, 8'h01);
        chk({7'h00, req_pin_zero}, 8'h01);
        pin(0, 1'b1);
        wt(6);
        chk({6'h00, req_pin_zero, wake}, 8'h01);
        @(posedge clock);
        core_sleeping <= 1'b0;
        wt(2);
        chk({6'h00, io_clk_run, wake}, 8'h02);
        pin(0, 1'b1);
        wr(2'h1, 8'h00);
        wr(2'h0, 8'h42);
        core_sleeping <= 1'b1;
        wt(3);
        chk({7'h00, io_clk_run}, 8'h01);
        pin(0, 1'b0);
        wt(6);
        rd(2'h2, 8'h40);
        @(posedge clock);
        core_sleeping <= 1'b0;
        $display("sleep test done");
        results();
    end
endmodule
`default_nettype wire
